// File: tkr_pkg.sv
// Package with constants and types of the touch key serial readout.
package tkr_pkg;

   // ==========================================================
   // Geometry
   localparam int NKEY       = 10;
   localparam int FIFO_DEPTH = 8;
   localparam int BIT_CNT_W  = 4;

   // ==========================================================
   // Timing, in their own units, and derived cycle counts
   localparam longint CLK_HZ      = 100_000_000;
   localparam longint T_RECOG_MS  = 20;
   localparam longint T_RESP_MS   = 60;
   localparam longint T_REQ_TO_US = 1000;
   localparam longint T_LOCK_S    = 10;
   localparam longint T_HIB_S     = 4;
   localparam longint T_SCK_MIN_US = 40;
   localparam int RECOG_CYC  = int'((CLK_HZ * T_RECOG_MS) / 1000);
   localparam int RESP_CYC   = int'((CLK_HZ * T_RESP_MS) / 1000);
   localparam int REQ_TO_CYC = int'((CLK_HZ * T_REQ_TO_US + 999_999) / 1_000_000);
   localparam int LOCK_CYC   = int'(CLK_HZ * T_LOCK_S);
   localparam int HIB_CYC    = int'(CLK_HZ * T_HIB_S);

   // ==========================================================
   // Reset values
   localparam logic LINE_IDLE = 1'b1;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_REQ   = 2'h1,
      ST_SHIFT = 2'h3
   } tkr_state_t;

   // Line levels of one key word: 0 is touched, 1 is released.
   typedef struct packed {
      logic [NKEY-1:0] level;
   } tkr_word_t;

endpackage

// File: tkr_fifo.sv
// Word FIFO with registered read data, between key sensing and the serial link.
`timescale 1ns/1ns
module tkr_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;

   wire              push       = in_valid & in_ready;
   wire              pop        = out_valid & out_ready;
   wire [AW-1:0]     next_rd    = rd_ptr + AW'(pop);
   wire              bypass     = push & (wr_ptr == next_rd);

   assign in_ready  = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // The head word is fetched one cycle ahead, so a word written into
   // the slot that becomes the head must bypass the array.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         out_data <= '0;
      end else begin
         wr_ptr   <= wr_ptr + AW'(push);
         rd_ptr   <= next_rd;
         count    <= count + (AW+1)'(push) - (AW+1)'(pop);
         out_data <= bypass ? in_data : mem[next_rd];
      end
   end

endmodule

// File: tkr_readout.sv
// Ten-key touch sensing core with its host-clocked three-wire readout port.
//
// Overview of operation
// (RQ1) Any key change pulls notification and data lines low to request a read.
// (RQ2) First falling shift clock edge of a request returns both lines high.
// (RQ3) A request without clock edge for over 1 ms releases both lines.
// (RQ4) Host holds each shift clock phase high and low at least 40 us.
// (RQ5) Host gives exactly 11 clock periods per read; the last ends data.
// (RQ6) Without request or transfer the data line stays high.
// (RQ7) A touched key reads low, a released key reads high.
// (RQ8) Word bit n carries the state of key n.
// (RQ9) Host clocks only after a request; clocking otherwise yields no data.
// (RQ10) A touch is recognised and reported within 60 ms.
// (RQ11) Only one key is active; others wait until it is released.
// (RQ12) A key held over 10 s is locked out, output left unchanged.
// (RQ13) Key bits shift out from key nine down to key zero.
// (RQ14) Four seconds with all keys idle enters hibernation.
// (RQ15) Host leaves at least 30 ms between successive reads.
// (RQ16) Data changes after falling edges; host samples on rising edges.
`timescale 1ns/1ns
module tkr_readout #(
   parameter int RECOG_CYC  = tkr_pkg::RECOG_CYC,
   parameter int REQ_TO_CYC = tkr_pkg::REQ_TO_CYC,
   parameter int LOCK_CYC   = tkr_pkg::LOCK_CYC,
   parameter int HIB_CYC    = tkr_pkg::HIB_CYC,
   parameter int FIFO_DEPTH = tkr_pkg::FIFO_DEPTH
) (
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire logic [tkr_pkg::NKEY-1:0] touch_key_inputs,
   input  wire logic                     shift_clk,
   output logic                          notify_n,
   output logic                          key_data,
   output logic      [tkr_pkg::NKEY-1:0] key_state,
   output logic                          key_locked,
   output logic                          hibernate
);
   localparam int N   = tkr_pkg::NKEY;
   localparam int DW  = $clog2(RECOG_CYC + 1);
   localparam int TW  = $clog2(REQ_TO_CYC + 1);
   localparam int LW  = $clog2(LOCK_CYC + 1);
   localparam int HW  = $clog2(HIB_CYC + 1);
   localparam int BW  = tkr_pkg::BIT_CNT_W;

   // ==========================================================
   // Lowest-index key of a set, as a one-hot word.
   function automatic logic [N-1:0] tkr_first(input logic [N-1:0] v);
      tkr_first = v & (~v + N'(1));
   endfunction

   // ==========================================================
   // Input synchronisers
   logic [N-1:0]        key_s1;
   logic [N-1:0]        key_s2;
   logic                sck_s1;
   logic                sck_s2;
   logic                sck_d;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_s1 <= '0;
         key_s2 <= '0;
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_d  <= 1'b1;
      end else begin
         key_s1 <= touch_key_inputs;
         key_s2 <= key_s1;
         sck_s1 <= shift_clk;
         sck_s2 <= sck_s1;
         sck_d  <= sck_s2;
      end
   end

   wire                 sck_fall = sck_d & ~sck_s2;
   wire                 sck_rise = ~sck_d & sck_s2;

   // ==========================================================
   // Touch recognition filter, one per key
   // A level must hold for the whole filter time before it counts, which
   // trades some latency for immunity to short disturbances.
   wire [N-1:0]         deb;

   for (genvar i = 0; i < N; i++) begin : g_key
      logic [DW-1:0]    cnt;
      logic             lvl;
      wire              moved = key_s2[i] != lvl;

      // Each key keeps its filtered level in its own flip-flop so that no
      // vector is written from several processes.
      assign deb[i] = lvl;

      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            cnt <= '0;
            lvl <= 1'b0;
         end else if (!moved) begin
            cnt <= '0;
         end else if (cnt == DW'(RECOG_CYC - 1)) begin
            cnt <= '0;
            lvl <= key_s2[i];                                      // [RQ10]
         end else begin
            cnt <= cnt + 1'b1;
         end
      end

      a_recog_bound: assert property (@(posedge ref_clk) disable iff (!arst_n)  // [RQ10]
         moved && cnt == DW'(RECOG_CYC - 1) |=> lvl == $past(key_s2[i]) && cnt == '0)
         else $error("recognition filter did not take the held level");
   end

   // ==========================================================
   // Single active key, lockout and reporting
   logic                fifo_in_ready;
   logic [LW-1:0]       hold_cnt;
   logic [HW-1:0]       idle_cnt;

   wire                 any_deb     = |deb;
   wire [N-1:0]         pick        = tkr_first(deb);             // [RQ11]
   wire                 active_gone = (key_state & deb) == '0;
   wire [N-1:0]         next_report = key_locked        ? key_state :     // [RQ12]
                                      (key_state == '0) ? pick :
                                      active_gone       ? '0 : key_state;
   wire                 change      = next_report != key_state;
   wire                 commit      = change & fifo_in_ready;
   tkr_pkg::tkr_word_t  push_word;

   // A touched key is a low line level.
   assign push_word.level = ~next_report;                          // [RQ7] [RQ8]

   // When the FIFO is full the change is held back, not dropped, so the host
   // still sees the latest key state once it catches up.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_state <= '0;
      end else if (commit) begin
         key_state <= next_report;                                 // [RQ11]
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_cnt   <= '0;
         key_locked <= 1'b0;
      end else if (key_locked) begin
         key_locked <= any_deb;                                    // [RQ12]
         hold_cnt   <= '0;
      end else if (key_state == '0) begin
         hold_cnt   <= '0;
      end else if (hold_cnt == LW'(LOCK_CYC - 1)) begin
         key_locked <= 1'b1;                                       // [RQ12]
      end else begin
         hold_cnt   <= hold_cnt + 1'b1;
      end
   end

   wire                 keys_idle = !any_deb && key_state == '0;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_cnt  <= '0;
         hibernate <= 1'b0;
      end else if (!keys_idle) begin
         idle_cnt  <= '0;
         hibernate <= 1'b0;
      end else if (idle_cnt == HW'(HIB_CYC - 1)) begin
         hibernate <= 1'b1;                                        // [RQ14]
      end else begin
         idle_cnt  <= idle_cnt + 1'b1;
      end
   end

   // ==========================================================
   // Change word FIFO
   logic                fifo_out_valid;
   tkr_pkg::tkr_word_t  fifo_out_data;
   tkr_pkg::tkr_state_t state;
   wire                 fifo_out_ready = state == tkr_pkg::ST_IDLE;

   tkr_fifo #(
      .WIDTH (N),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .in_valid  (change),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ==========================================================
   // Serial link
   // The shift clock is sampled on ref_clk, so the host phases must be
   // several ref_clk periods long; the 40 us minimum leaves a wide margin.
   tkr_pkg::tkr_word_t  shreg;
   logic [BW-1:0]       bit_cnt;
   logic [TW-1:0]       timer;

   wire                 timeout  = timer == TW'(REQ_TO_CYC);
   wire                 last_bit = bit_cnt == BW'(N);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= tkr_pkg::ST_IDLE;
         notify_n <= tkr_pkg::LINE_IDLE;
         key_data <= tkr_pkg::LINE_IDLE;
         shreg    <= '0;
         bit_cnt  <= '0;
         timer    <= '0;
      end else begin
         unique case (state)
            tkr_pkg::ST_IDLE: begin
               // Edges on the shift clock are ignored here.            [RQ9]
               timer <= '0;
               if (fifo_out_valid) begin
                  state    <= tkr_pkg::ST_REQ;
                  notify_n <= 1'b0;                                // [RQ1]
                  key_data <= 1'b0;                                // [RQ1]
                  shreg    <= fifo_out_data;
               end
            end
            tkr_pkg::ST_REQ: begin
               if (sck_fall) begin
                  state    <= tkr_pkg::ST_SHIFT;
                  notify_n <= 1'b1;                                // [RQ2]
                  key_data <= 1'b1;                                // [RQ2]
                  bit_cnt  <= '0;
                  timer    <= '0;
               end else if (timeout) begin
                  state    <= tkr_pkg::ST_IDLE;
                  notify_n <= 1'b1;                                // [RQ3]
                  key_data <= 1'b1;                                // [RQ3]
               end else begin
                  timer    <= timer + 1'b1;
               end
            end
            tkr_pkg::ST_SHIFT: begin
               if (sck_fall) begin
                  key_data    <= shreg.level[N-1];                 // [RQ13] [RQ16]
                  shreg.level <= {shreg.level[N-2:0], 1'b1};
                  timer       <= '0;
               end else if (sck_rise) begin
                  timer <= '0;
                  if (last_bit) begin
                     state    <= tkr_pkg::ST_IDLE;
                     key_data <= 1'b1;                             // [RQ5] [RQ6]
                  end else begin
                     bit_cnt  <= bit_cnt + 1'b1;
                  end
               end else if (timeout) begin
                  state    <= tkr_pkg::ST_IDLE;
                  key_data <= 1'b1;                                // [RQ6]
               end else begin
                  timer    <= timer + 1'b1;
               end
            end
            default: begin
               state    <= tkr_pkg::ST_IDLE;
               notify_n <= 1'b1;
               key_data <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_word_ready;
      state == tkr_pkg::ST_IDLE && fifo_out_valid;
   endsequence

   sequence s_lines_low;
      !notify_n && !key_data && state == tkr_pkg::ST_REQ;
   endsequence

   sequence s_lines_high;
      notify_n && key_data;
   endsequence

   a_request_low: assert property (s_word_ready |=> s_lines_low)   // [RQ1]
      else $error("pending word did not pull both lines low");

   a_ack_release: assert property (                                // [RQ2]
      state == tkr_pkg::ST_REQ && sck_fall |=> s_lines_high ##0 state == tkr_pkg::ST_SHIFT)
      else $error("first falling edge did not release the lines");

   a_req_timeout: assert property (                                // [RQ3]
      state == tkr_pkg::ST_REQ && timeout && !sck_fall
      |=> s_lines_high ##0 state == tkr_pkg::ST_IDLE)
      else $error("stale request was not released");

   a_idle_high: assert property (                                  // [RQ6]
      state == tkr_pkg::ST_IDLE |-> key_data && notify_n)
      else $error("data line not high while idle");

   a_bit_order: assert property (                                  // [RQ13]
      state == tkr_pkg::ST_SHIFT && sck_fall
      |=> key_data == $past(shreg.level[N-1]) && $past(bit_cnt) == bit_cnt)
      else $error("key bit not driven after falling edge");

   a_word_end: assert property (                                   // [RQ5]
      state == tkr_pkg::ST_SHIFT && sck_rise && last_bit
      |=> state == tkr_pkg::ST_IDLE && key_data)
      else $error("transfer did not end on the last rising edge");

   a_single_key: assert property ($onehot0(key_state))             // [RQ11]
      else $error("more than one key reported active");

   a_lock_freeze: assert property (
      key_locked && any_deb |=> $stable(key_state))                // [RQ12]
      else $error("locked key output changed");

   a_hib_entry: assert property (                                  // [RQ14]
      keys_idle && !hibernate && idle_cnt == HW'(HIB_CYC - 1) |=> hibernate)
      else $error("hibernation not entered after idle time");

   a_word_polarity: assert property (                              // [RQ7]
      commit |=> fifo_out_valid && key_state == $past(next_report) ##0 $past(push_word.level) == ~key_state)
      else $error("key word polarity wrong");

endmodule

// File: tkr_host_model.sv
// Behavioural host that clocks key words out of the readout link.
`timescale 1ns/1ns
module tkr_host_model #(
   parameter int HALF_NS = 80,
   parameter int GAP_NS  = 300
) (
   input  wire logic        enable,
   input  wire logic        poll,
   input  wire logic        notify_n,
   input  wire logic        key_data,
   output logic             shift_clk,
   output logic      [10:0] word,
   output logic             ack_notify,
   output logic      [7:0]  read_cnt
);
   // ==========================================================
   // Read loop
   // The clock stands high outside frames; phases and the gap are scaled down from the real figures.
   initial begin
      shift_clk  = 1'b1;
      word       = 11'h000;
      ack_notify = 1'b0;
      read_cnt   = 8'h00;
      forever begin
         wait (enable && (!notify_n || poll));
         #(HALF_NS / 2 + 3);
         for (int i = 0; i < 11; i++) begin
            shift_clk = 1'b0;
            #(HALF_NS);
            shift_clk = 1'b1;
            word[10 - i] = key_data;
            if (i == 0) begin
               ack_notify = notify_n;
            end
            #(HALF_NS);
         end
         read_cnt = read_cnt + 8'h01;
         #(GAP_NS);
      end
   end
endmodule

// File: tb.sv
// Self-checking bench for the touch key serial readout.
`timescale 1ns/1ns
module tb;
   localparam int RECOG  = 8;
   localparam int REQ_TO = 200;
   localparam int LOCK   = 400;
   localparam int HIB    = 300;

   logic        ref_clk;
   logic        arst_n;
   logic        shift_clk;
   logic        notify_n;
   logic        key_data;
   logic        key_locked;
   logic        hibernate;
   logic        host_en;
   logic        host_poll;
   logic        ack_notify;
   logic [9:0]  keys;
   logic [9:0]  key_state;
   logic [10:0] word;
   logic [7:0]  read_cnt;
   int          mismatches;
   int          checks;
   int          cycles = 0;

   tkr_readout #(.RECOG_CYC(RECOG), .REQ_TO_CYC(REQ_TO), .LOCK_CYC(LOCK), .HIB_CYC(HIB), .FIFO_DEPTH(8)) i_dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .touch_key_inputs(keys), .shift_clk(shift_clk),
      .notify_n(notify_n), .key_data(key_data), .key_state(key_state), .key_locked(key_locked),
      .hibernate(hibernate));

   tkr_host_model #(.HALF_NS(80), .GAP_NS(300)) i_host (
      .enable(host_en), .poll(host_poll), .notify_n(notify_n), .key_data(key_data),
      .shift_clk(shift_clk), .word(word), .ack_notify(ack_notify), .read_cnt(read_cnt));

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   // ==========================================================
   // Common tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A stuck design must not hang the run, so the cycle count has a ceiling.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic wait_read(input logic [7:0] n);
      for (int i = 0; i < 3000 && read_cnt !== n; i++) @(negedge ref_clk);
      check(read_cnt, n);
   endtask

   task automatic wait_notify(output int t);
      t = 0;
      while (notify_n !== 1'b0 && t < 200) begin
         cyc(1);
         t++;
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check({notify_n, key_data, key_locked, hibernate}, 4'hC);
      check(key_state, 10'h000);
      $display("test reset done");
   endtask

   task automatic t_press_release(input int k);
      logic [7:0] n;
      int         t;
      n = read_cnt;
      keys[k] = 1'b1;
      wait_notify(t);
      check({notify_n, key_data}, 2'h0);
      check(t < RECOG + 16, 1'b1);
      wait_read(n + 8'h01);
      check(word, {1'b1, ~(10'h001 << k)});
      check(ack_notify, 1'b1);
      check(key_state, 10'h001 << k);
      check({notify_n, key_data}, 2'h3);
      keys[k] = 1'b0;
      wait_read(n + 8'h02);
      check(word, 11'h7FF);
      $display("test press_release key %0d done", k);
   endtask

   task automatic t_timeout();
      logic [7:0] n;
      int         t;
      host_en = 1'b0;
      n = read_cnt;
      keys[1] = 1'b1;
      wait_notify(t);
      check({notify_n, key_data}, 2'h0);
      cyc(REQ_TO - 20);
      check({notify_n, key_data}, 2'h0);
      cyc(30);
      check({notify_n, key_data}, 2'h3);
      host_en = 1'b1;
      keys[1] = 1'b0;
      wait_read(n + 8'h01);
      check(word, 11'h7FF);
      $display("test timeout done");
   endtask

   task automatic t_poll();
      logic [7:0] n;
      n = read_cnt;
      host_poll = 1'b1;
      wait_read(n + 8'h01);
      host_poll = 1'b0;
      check(word, 11'h7FF);
      check(notify_n, 1'b1);
      $display("test poll done");
   endtask

   task automatic t_single_lock();
      logic [7:0] n;
      n = read_cnt;
      keys[2] = 1'b1;
      wait_read(n + 8'h01);
      keys[4] = 1'b1;
      cyc(RECOG + 40);
      check(key_state, 10'h004);
      check(read_cnt, n + 8'h01);
      cyc(LOCK + 50);
      check(key_locked, 1'b1);
      check(key_state, 10'h004);
      keys = 10'h000;
      wait_read(n + 8'h02);
      check(word, 11'h7FF);
      check(key_locked, 1'b0);
      $display("test single_lock done");
   endtask

   task automatic t_hibernate();
      cyc(HIB + 20);
      check(hibernate, 1'b1);
      t_press_release(7);
      check(hibernate, 1'b0);
      $display("test hibernate done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      arst_n     = 1'b0;
      keys       = 10'h000;
      host_en    = 1'b1;
      host_poll  = 1'b0;
      mismatches = 0;
      checks     = 0;
      repeat (16) @(negedge ref_clk);
      arst_n = 1'b1;
      t_reset();
      cyc(5);
      t_poll();
      t_press_release(0);
      t_press_release(9);
      t_press_release(5);
      t_timeout();
      t_single_lock();
      t_hibernate();
      end_of_test();
   end
endmodule
